// *** verilog/tmt_test_mode_trim_access.v ***
// test-mode trim register: selector, trim word and oscillator test bits
//
// Functional notes
// - trim word bits 5:0 exchange value with trim register chosen by bits 7:6
// - in test mode a write loads trim value into selected trim register
// - trim word read returns the live selected trim register contents
// - trim registers load from flash information block during the power-on load
// - without test mode enable reads give zero and writes are ignored
// - selector 00 front-end pll, 01 system pll, 10 bandgap, 11 flash oscillator
// - bits 8 and 9 test the system crystal oscillator
// - selector and test bits clear on power-on reset or test-logic-reset state; trim registers clear on power-on reset only
// - bits 11:0 accessible only while test mode enable is set
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "tmt_defines.vh"
module tmt_test_mode_trim_access #(
    parameter TRIM_WIDTH = `TMT_TRIM_WIDTH
) (
    // clock, reset, enable
    input wire i_mclk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_tap_logic_reset,
    // test mode control
    input wire i_test_mode_enable,
    // register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [`TMT_REG_WIDTH-1:0] i_reg_wdata,
    output reg [`TMT_REG_WIDTH-1:0] o_reg_rdata,
    // flash information block values, presented during the power-on load
    input wire i_por_load,
    input wire [TRIM_WIDTH-1:0] i_flash_afe_pll,
    input wire [TRIM_WIDTH-1:0] i_flash_sys_pll,
    input wire [TRIM_WIDTH-1:0] i_flash_bandgap,
    input wire [TRIM_WIDTH-1:0] i_flash_flash_osc,
    // trim outputs to analog
    output wire [TRIM_WIDTH-1:0] o_trim_afe_pll,
    output wire [TRIM_WIDTH-1:0] o_trim_sys_pll,
    output wire [TRIM_WIDTH-1:0] o_trim_bandgap,
    output wire [TRIM_WIDTH-1:0] o_trim_flash_osc,
    // oscillator test bits
    output wire [1:0] o_primary_oscillator_test_bits,
    output wire [1:0] o_afe_oscillator_test_bits
);
    reg rst_meta;
    reg rst_sync;
    reg [1:0] trim_target_select;
    reg [1:0] osc1_bits;
    reg [1:0] xt2_bits;
    reg [TRIM_WIDTH-1:0] sel_trim;
    reg [`TMT_REG_WIDTH-1:0] next_rdata;
    wire [TRIM_WIDTH*`TMT_NUM_TRIM-1:0] flash_bus;
    wire [TRIM_WIDTH*`TMT_NUM_TRIM-1:0] trim_bus;
    wire wr_ok;
    wire [1:0] wr_sel;

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign wr_ok = i_reg_wr & i_test_mode_enable;
    assign wr_sel = i_reg_wdata[`TMT_SEL_MSB:`TMT_SEL_LSB];
    assign flash_bus = {i_flash_flash_osc, i_flash_bandgap, i_flash_sys_pll, i_flash_afe_pll};

    genvar g;
    generate
        for (g = 0; g < `TMT_NUM_TRIM; g = g + 1) begin : g_trim
            tmt_trim_cell #(
                .WIDTH(TRIM_WIDTH)
            ) u_cell (
                .i_mclk(i_mclk),
                .i_rst_n(rst_sync),
                .i_ce(i_ce),
                .i_por_load(i_por_load),
                .i_flash_value(flash_bus[g*TRIM_WIDTH +: TRIM_WIDTH]),
                .i_wr(wr_ok && (wr_sel == g)),
                .i_wr_value(i_reg_wdata[`TMT_TRIM_MSB:`TMT_TRIM_LSB]),
                .o_trim(trim_bus[g*TRIM_WIDTH +: TRIM_WIDTH])
            );
        end
    endgenerate

    assign o_trim_afe_pll = trim_bus[0 +: TRIM_WIDTH];
    assign o_trim_sys_pll = trim_bus[TRIM_WIDTH +: TRIM_WIDTH];
    assign o_trim_bandgap = trim_bus[2*TRIM_WIDTH +: TRIM_WIDTH];
    assign o_trim_flash_osc = trim_bus[3*TRIM_WIDTH +: TRIM_WIDTH];
    assign o_primary_oscillator_test_bits = osc1_bits;
    assign o_afe_oscillator_test_bits = xt2_bits;

    // control bits of the register
    always @(posedge i_mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            trim_target_select <= `TMT_ZERO2;
            osc1_bits <= `TMT_ZERO2;
            xt2_bits <= `TMT_ZERO2;
        end else if (i_ce) begin
            if (i_tap_logic_reset) begin
                trim_target_select <= `TMT_ZERO2;
                osc1_bits <= `TMT_ZERO2;
                xt2_bits <= `TMT_ZERO2;
            end else if (wr_ok) begin
                trim_target_select <= wr_sel;
                osc1_bits <= i_reg_wdata[`TMT_OSC1_MSB:`TMT_OSC1_LSB];
                xt2_bits <= i_reg_wdata[`TMT_XT2_MSB:`TMT_XT2_LSB];
            end
        end
    end

    // live view of the selected trim register
    always @* begin
        case (trim_target_select)
            `TMT_SEL_AFE_PLL: sel_trim = trim_bus[0 +: TRIM_WIDTH];
            `TMT_SEL_SYS_PLL: sel_trim = trim_bus[TRIM_WIDTH +: TRIM_WIDTH];
            `TMT_SEL_BANDGAP: sel_trim = trim_bus[2*TRIM_WIDTH +: TRIM_WIDTH];
            default: sel_trim = trim_bus[3*TRIM_WIDTH +: TRIM_WIDTH];
        endcase
    end

    always @* begin
        next_rdata = `TMT_ZERO16;
        if (i_reg_rd && i_test_mode_enable) begin
            next_rdata[`TMT_TRIM_MSB:`TMT_TRIM_LSB] = sel_trim;
            next_rdata[`TMT_SEL_MSB:`TMT_SEL_LSB] = trim_target_select;
            next_rdata[`TMT_OSC1_MSB:`TMT_OSC1_LSB] = osc1_bits;
            next_rdata[`TMT_XT2_MSB:`TMT_XT2_LSB] = xt2_bits;
        end
    end

    always @(posedge i_mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            o_reg_rdata <= `TMT_ZERO16;
        end else if (i_ce) begin
            o_reg_rdata <= next_rdata;
        end
    end
endmodule // tmt_test_mode_trim_access

// *** verilog/tmt_defines.vh ***
// constants for the test-mode trim access block
`ifndef TMT_DEFINES_VH
`define TMT_DEFINES_VH
`define TMT_REG_WIDTH 16
`define TMT_TRIM_WIDTH 6
`define TMT_TRIM_LSB 0
`define TMT_TRIM_MSB 5
`define TMT_SEL_LSB 6
`define TMT_SEL_MSB 7
`define TMT_OSC1_LSB 8
`define TMT_OSC1_MSB 9
`define TMT_XT2_LSB 10
`define TMT_XT2_MSB 11
`define TMT_NUM_TRIM 4
`define TMT_SEL_AFE_PLL 2'h0
`define TMT_SEL_SYS_PLL 2'h1
`define TMT_SEL_BANDGAP 2'h2
`define TMT_SEL_FLASH_OSC 2'h3
`define TMT_ZERO16 16'h0000
`define TMT_ZERO6 6'h00
`define TMT_ZERO2 2'h0
`define TMT_ZERO4 4'h0
`endif

// *** verilog/tmt_trim_cell.v ***
// one internal trim register: power-on load, test-mode override
`timescale 1ns/1ns
`include "tmt_defines.vh"
module tmt_trim_cell #(
    parameter WIDTH = `TMT_TRIM_WIDTH
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_ce,
    // load sources
    input wire i_por_load,
    input wire [WIDTH-1:0] i_flash_value,
    input wire i_wr,
    input wire [WIDTH-1:0] i_wr_value,
    // held trim
    output reg [WIDTH-1:0] o_trim
);
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_trim <= {WIDTH{1'b0}};
        end else if (i_ce) begin
            if (i_por_load) begin
                o_trim <= i_flash_value;
            end else if (i_wr) begin
                o_trim <= i_wr_value;
            end
        end
    end
endmodule // tmt_trim_cell

// *** tb/tmt_props_properties.sv ***
// assertions for the test-mode trim register
`timescale 1ns/1ns
module tmt_props #(parameter TRIM_WIDTH = 6) (
    // watched ports
    input wire i_mclk, i_resetn, i_ce, i_tap_logic_reset, i_test_mode_enable, i_reg_wr, i_reg_rd, i_por_load,
    input wire [15:0] i_reg_wdata, o_reg_rdata,
    input wire [TRIM_WIDTH-1:0] i_flash_afe_pll, i_flash_sys_pll, i_flash_bandgap, i_flash_flash_osc,
    input wire [TRIM_WIDTH-1:0] o_trim_afe_pll, o_trim_sys_pll, o_trim_bandgap, o_trim_flash_osc,
    input wire [1:0] o_primary_oscillator_test_bits, o_afe_oscillator_test_bits
);
    wire [4*TRIM_WIDTH-1:0] all = {o_trim_flash_osc, o_trim_bandgap, o_trim_sys_pll, o_trim_afe_pll};
    wire [4*TRIM_WIDTH-1:0] fl = {i_flash_flash_osc, i_flash_bandgap, i_flash_sys_pll, i_flash_afe_pll};
    wire wen = i_ce && i_reg_wr && i_test_mode_enable && !i_por_load;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    wr_load_a: assert property (wen |=> all[$past(i_reg_wdata[7:6])*TRIM_WIDTH +: TRIM_WIDTH]
        == $past(i_reg_wdata[5:0])) else $error("write missed trim");
    sel_map_a: assert property (wen && i_reg_wdata[7:6] == 2'b11 |=>
        o_trim_flash_osc == $past(i_reg_wdata[5:0])) else $error("select decode wrong");
    trim_hold_a: assert property (!(i_ce && (i_por_load || i_reg_wr && i_test_mode_enable)) |=>
        $stable(all)) else $error("trim changed");
    por_load_a: assert property (i_ce && i_por_load |=> all == $past(fl)) else $error("flash load");
    rd_lock_a: assert property (i_ce && i_reg_rd && !i_test_mode_enable |=> o_reg_rdata == 16'h0000)
        else $error("locked read not zero");
    rd_live_a: assert property (i_ce && i_reg_rd && i_test_mode_enable && !i_por_load && !i_tap_logic_reset
        |=> o_reg_rdata[5:0] == TRIM_WIDTH'(all >> (o_reg_rdata[7:6] * TRIM_WIDTH))
        && o_reg_rdata[9:8] == o_primary_oscillator_test_bits) else $error("readback not live");
    osc_bits_a: assert property (wen && !i_tap_logic_reset |=>
        o_primary_oscillator_test_bits == $past(i_reg_wdata[9:8])) else $error("test bits");
    tap_clr_a: assert property (i_ce && i_tap_logic_reset |=>
        o_primary_oscillator_test_bits == 2'h0 && o_afe_oscillator_test_bits == 2'h0) else $error("tap clear");
    rsvd_zero_a: assert property (o_reg_rdata[15:12] == 4'h0) else $error("reserved bits set");
    cover property (wen);
    cover property (i_reg_rd && i_test_mode_enable);
    cover property (i_por_load);
endmodule // tmt_props
bind tmt_test_mode_trim_access tmt_props #(.TRIM_WIDTH(TRIM_WIDTH)) u_props (.*);

// *** tb/tb.sv ***
// self-checking bench for the test-mode trim register
`timescale 1ns/1ns
module tb;
    logic i_mclk = 0, i_resetn = 0, i_ce = 1, tap = 0, en = 0, wr = 0, rd = 0, por = 0;
    logic [15:0] wd = 0, d;
    logic [5:0] f[4] = '{default: 0}, t[4];
    logic [1:0] sel, xa, xb;
    wire [15:0] rdata;
    wire [5:0] tr[4];
    wire [1:0] osc1, osc2;
    int fails = 0, check_count = 0, i;
    always #20 i_mclk = ~i_mclk;
    tmt_test_mode_trim_access dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_tap_logic_reset(tap),
        .i_test_mode_enable(en), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
        .i_por_load(por), .i_flash_afe_pll(f[0]), .i_flash_sys_pll(f[1]), .i_flash_bandgap(f[2]),
        .i_flash_flash_osc(f[3]), .o_trim_afe_pll(tr[0]), .o_trim_sys_pll(tr[1]), .o_trim_bandgap(tr[2]),
        .o_trim_flash_osc(tr[3]), .o_primary_oscillator_test_bits(osc1), .o_afe_oscillator_test_bits(osc2));
    task chk(input logic [23:0] g, e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task ct;
        #1 chk({tr[3], tr[2], tr[1], tr[0]}, {t[3], t[2], t[1], t[0]});
        chk({20'h0_0000, osc2, osc1}, {20'h0_0000, xb, xa});
    endtask
    task wrt(input logic [15:0] v);
        @(posedge i_mclk) {wr, wd} <= {1'b1, v};
        @(posedge i_mclk) wr <= 0;
        if (en && i_ce) {xb, xa, sel, t[v[7:6]]} = v[11:0];
    endtask
    task rdc;
        @(posedge i_mclk) rd <= 1;
        @(posedge i_mclk) rd <= 0;
        #1 chk({8'h00, rdata}, en ? {12'h000, xb, xa, sel, t[sel]} : 24'h00_0000);
    endtask
    task end_of_test;
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h5775_c0e7));
        {sel, xa, xb} = 0;
        repeat (5) @(posedge i_mclk);
        i_resetn <= 1;
        repeat (3) @(posedge i_mclk);
        for (i = 0; i < 4; i++) f[i] <= 6'($urandom);
        por <= 1;
        @(posedge i_mclk) por <= 0;
        t = f;
        ct;
        @(posedge i_mclk) en <= 1;
        for (i = 0; i < 24; i++) begin
            d = 16'($urandom);
            d[7:6] = i[1:0];
            wrt(d);
            ct;
            rdc;
        end
        @(posedge i_mclk) i_ce <= 0;
        wrt(16'($urandom));
        ct;
        @(posedge i_mclk) begin
            i_ce <= 1;
            for (i = 0; i < 4; i++) f[i] <= t[i];
        end
        wrt(16'($urandom));
        @(posedge i_mclk) por <= 1;
        @(posedge i_mclk) por <= 0;
        t = f;
        ct;
        @(posedge i_mclk) en <= 0;
        wrt(16'($urandom));
        ct;
        rdc;
        @(posedge i_mclk) {tap, en} <= 2'b11;
        @(posedge i_mclk) tap <= 0;
        {sel, xa, xb} = 0;
        rdc;
        @(posedge i_mclk) i_resetn <= 0;
        @(posedge i_mclk) i_resetn <= 1;
        t = '{default: 0};
        ct;
        end_of_test;
    end
endmodule // tb
